// ---- verilog/tcr_config_bank.sv ----
// Tuner configuration register bank behind a 2-wire serial bus
`timescale 1ns/1ps
module tcr_config_bank
    import tcr_pkg::*;
#(
    parameter logic [6:0] BUS_ADDR_BASE = 7'h60
) (
    input wire logic CLK_SYS,
    input wire logic RSTN,
    input wire logic SCL,
    input wire logic SDA_IN,
    output logic SDA_OUT,
    output logic SDA_OE_N,
    input wire logic ADDR_SEL,
    input wire logic POR_FLAG,
    input wire logic AUTOSELECT_ACTIVE_FLAG,
    input wire logic AUTOSELECT_END_FLAG,
    input wire logic LOCK_INDICATION,
    input wire logic [4:0] SELECTED_OSC_NUMBER,
    input wire logic [2:0] TUNE_ADC_VALUE,
    output logic FRACTIONAL_MODE_BIT,
    output logic [14:0] INT_DIVIDE,
    output logic [19:0] FRACTIONAL_MODE_BIT_DIVIDE,
    output logic [1:0] PUMP_MIN_PULSE,
    output logic [1:0] PUMP_LINEARITY,
    output logic [2:0] CRYSTAL_OUT_DIVIDER,
    output logic [4:0] REF_DIVIDER,
    output logic OSC_POST_DIVIDER_SEL,
    output logic PUMP_CURRENT_SOURCE_SEL,
    output logic PUMP_CURRENT_LEVEL,
    output logic [4:0] OSC_START_NUMBER,
    output logic OSC_AUTOSELECT_ENABLE,
    output logic TUNE_ADC_LATCH,
    output logic TUNE_ADC_READ_ENABLE,
    output logic [7:0] LOWPASS_TRIM,
    output logic FACTORY_POWER_DOWN,
    output logic [3:0] BASEBAND_GAIN,
    output logic [6:0] BLOCK_SHUTDOWN,
    output logic [2:0] PUMP_TEST_MODE,
    output logic PUMP_FAST_LOCK,
    output logic [2:0] LOCK_DETECT_MUX_SEL,
    output logic SIGNAL_PATH_EN,
    output logic SYNTH_EN,
    output logic AUTOSELECT_START
);
    // Link domain
    tcr_link_e lk_state;
    logic [3:0] bit_cnt;
    logic [7:0] shift;
    logic [3:0] ptr;
    logic ptr_tgl;
    logic wr_tgl;
    logic [3:0] wr_ptr;
    logic [7:0] wr_byte;
    logic drive_low;
    logic addr_pin_s;
    logic addr_hit;
    logic link_rst_n;
    logic ack_slot;
    // System domain
    logic [1:0] pin_s;
    logic [1:0] tgl_s;
    logic [1:0] tgl_d;
    logic [STATUS_W-1:0] stat_s;
    logic sda_d;
    logic framed;
    logic hold_clr;
    logic start_seen;
    logic stop_seen;
    logic wr_seen;
    logic ptr_seen;
    logic [7:0] rd_hold;
    logic [7:0] cfg [CFG_COUNT];
    logic any_wr;

    function automatic logic wr_hit(input logic [3:0] idx);
        return wr_seen && (wr_ptr == idx);
    endfunction

    // ---------------------------------------------------------
    // Link domain: bit counter and shifter on SCL
    // ---------------------------------------------------------
    assign link_rst_n = RSTN & ~hold_clr;
    assign ack_slot = (bit_cnt == ACK_SLOT);
    assign addr_hit = (shift[7:1] == {BUS_ADDR_BASE[6:1], addr_pin_s});

    // Strap caught on the link clock after reset release
    tcr_sync #(.WIDTH(1)) u_addr_sync (
        .clk(SCL),
        .rst_n(RSTN),
        .d(ADDR_SEL),
        .q(addr_pin_s)
    );

    // Sample data on rising clock, nine slots a byte
    always_ff @(posedge SCL or negedge link_rst_n)
    begin
        if (!link_rst_n)
        begin
            bit_cnt <= '0;
            shift <= '0;
        end
        else
        begin
            shift <= ack_slot ? shift : {shift[6:0], SDA_IN};
            bit_cnt <= ack_slot ? '0 : bit_cnt + 4'h1;
        end
    end

    // Byte phase sequencing
    always_ff @(posedge SCL or negedge link_rst_n)
    begin
        if (!link_rst_n)
            lk_state <= LK_ADDR;
        else if (ack_slot)
        begin
            unique case (lk_state)
                LK_ADDR: lk_state <= !addr_hit ? LK_IGNORE : (shift[0] ? LK_RDATA : LK_PTR);
                LK_PTR: lk_state <= LK_WDATA;
                LK_RDATA: lk_state <= SDA_IN ? LK_IGNORE : LK_RDATA; // Nack ends read
                LK_WDATA: lk_state <= LK_WDATA;
                LK_IGNORE: lk_state <= LK_IGNORE;
            endcase
        end
    end

    // Register pointer, auto-increment, refresh toggle
    // Kept across frames so a read after repeated start uses it
    always_ff @(posedge SCL or negedge RSTN)
    begin
        if (!RSTN)
        begin
            ptr <= '0;
            ptr_tgl <= 1'b0;
        end
        else if (ack_slot)
        begin
            if (lk_state == LK_PTR)
                ptr <= shift[3:0];
            else if (lk_state == LK_WDATA || (lk_state == LK_RDATA && !SDA_IN))
                ptr <= ptr + 4'h1;
            if (lk_state != LK_IGNORE && (lk_state != LK_ADDR || addr_hit))
                ptr_tgl <= ~ptr_tgl;
        end
    end

    // Completed data byte handed to the system side
    always_ff @(posedge SCL or negedge RSTN)
    begin
        if (!RSTN)
        begin
            wr_tgl <= 1'b0;
            wr_ptr <= '0;
            wr_byte <= '0;
        end
        else if (ack_slot && lk_state == LK_WDATA && link_rst_n)
        begin
            wr_ptr <= ptr;
            wr_byte <= shift;
            wr_tgl <= ~wr_tgl;
        end
    end

    // Drive data low on falling clock: ack or read bits
    always_ff @(negedge SCL or negedge link_rst_n)
    begin
        if (!link_rst_n)
            drive_low <= 1'b0;
        else if (ack_slot)
            drive_low <= (lk_state == LK_ADDR && addr_hit) || lk_state == LK_PTR
                || lk_state == LK_WDATA;
        else if (lk_state == LK_RDATA)
            drive_low <= ~rd_hold[3'(BYTE_MSB - bit_cnt)];
        else
            drive_low <= 1'b0;
    end

    // Open-drain pin, enable low while pulling down
    assign SDA_OUT = 1'b0;
    assign SDA_OE_N = ~drive_low;

    // ---------------------------------------------------------
    // System domain: synchronisers
    // ---------------------------------------------------------
    tcr_sync #(.WIDTH(2)) u_pin_sync (
        .clk(CLK_SYS),
        .rst_n(RSTN),
        .d({SCL, SDA_IN}),
        .q(pin_s)
    );

    tcr_sync #(.WIDTH(2)) u_tgl_sync (
        .clk(CLK_SYS),
        .rst_n(RSTN),
        .d({wr_tgl, ptr_tgl}),
        .q(tgl_s)
    );

    tcr_sync #(.WIDTH(STATUS_W)) u_stat_sync (
        .clk(CLK_SYS),
        .rst_n(RSTN),
        .d({POR_FLAG, AUTOSELECT_ACTIVE_FLAG, AUTOSELECT_END_FLAG, LOCK_INDICATION,
            SELECTED_OSC_NUMBER, TUNE_ADC_VALUE}),
        .q(stat_s)
    );

    assign start_seen = pin_s[1] & sda_d & ~pin_s[0];
    assign stop_seen = pin_s[1] & ~sda_d & pin_s[0];
    assign wr_seen = tgl_s[1] ^ tgl_d[1];
    assign ptr_seen = tgl_s[0] ^ tgl_d[0];

    // Edge history for start, stop and toggles
    always_ff @(posedge CLK_SYS or negedge RSTN)
    begin
        if (!RSTN)
        begin
            sda_d <= 1'b1;
            tgl_d <= '0;
        end
        else
        begin
            sda_d <= pin_s[0];
            tgl_d <= tgl_s;
        end
    end

    // Link held clear outside frames, released once SCL is low
    always_ff @(posedge CLK_SYS or negedge RSTN)
    begin
        if (!RSTN)
        begin
            framed <= 1'b0;
            hold_clr <= 1'b1;
        end
        else
        begin
            if (start_seen)
                framed <= 1'b1;
            else if (stop_seen)
                framed <= 1'b0;
            if (start_seen || stop_seen)
                hold_clr <= 1'b1;
            else if (framed && !pin_s[1])
                hold_clr <= 1'b0;
        end
    end

    // ---------------------------------------------------------
    // Configuration registers
    // ---------------------------------------------------------
    always_ff @(posedge CLK_SYS or negedge RSTN)
    begin
        if (!RSTN)
        begin
            for (int i = 0; i < CFG_COUNT; i++)
                cfg[i] <= CFG_RESET[i];
        end
        else if (wr_seen && wr_ptr <= CFG_LAST)
            cfg[wr_ptr] <= wr_byte & CFG_MASK[wr_ptr];
    end

    // Autoselection start pulse, one cycle per trigger write
    always_ff @(posedge CLK_SYS or negedge RSTN)
    begin
        if (!RSTN)
            AUTOSELECT_START <= 1'b0;
        else
            AUTOSELECT_START <= wr_hit(AUTOSEL_TRIGGER_REG);
    end

    // Read byte refreshed whenever the pointer moves
    always_ff @(posedge CLK_SYS or negedge RSTN)
    begin
        if (!RSTN)
            rd_hold <= '0;
        else if (ptr_seen)
        begin
            if (ptr == REG_STAT1)
                rd_hold <= {stat_s[11:8], 4'h0};
            else if (ptr == REG_STAT2)
                rd_hold <= stat_s[7:0];
            else
                rd_hold <= 8'h00;
        end
    end

    // ---------------------------------------------------------
    // Field outputs
    // ---------------------------------------------------------
    assign FRACTIONAL_MODE_BIT = cfg[REG_INT_HIGH][FRACTIONAL_MODE_BIT_MODE_BIT];
    assign INT_DIVIDE = {cfg[REG_INT_HIGH][6:0], cfg[REG_INT_LOW]};
    assign FRACTIONAL_MODE_BIT_DIVIDE = {cfg[REG_PUMP][3:0], cfg[REG_FRACTIONAL_MODE_BIT_HIGH], cfg[REG_FRACTIONAL_MODE_BIT_LOW]};
    assign PUMP_MIN_PULSE = cfg[REG_PUMP][7:6];
    assign PUMP_LINEARITY = cfg[REG_PUMP][5:4];
    assign CRYSTAL_OUT_DIVIDER = cfg[REG_XTAL][7:5];
    assign REF_DIVIDER = cfg[REG_XTAL][4:0];
    assign OSC_POST_DIVIDER_SEL = cfg[REG_LOOP][POST_DIV_BIT];
    assign PUMP_CURRENT_SOURCE_SEL = cfg[REG_LOOP][CUR_SRC_BIT];
    assign PUMP_CURRENT_LEVEL = cfg[REG_LOOP][CUR_LVL_BIT];
    assign OSC_START_NUMBER = cfg[REG_OSC][7:3];
    assign OSC_AUTOSELECT_ENABLE = cfg[REG_OSC][AUTOSEL_BIT];
    assign TUNE_ADC_LATCH = cfg[REG_OSC][ADC_LATCH_BIT];
    assign TUNE_ADC_READ_ENABLE = cfg[REG_OSC][ADC_READ_BIT];
    assign LOWPASS_TRIM = cfg[REG_LPF];
    assign FACTORY_POWER_DOWN = cfg[REG_RX][FACTORY_PD_BIT];
    assign BASEBAND_GAIN = cfg[REG_RX][3:0];
    assign BLOCK_SHUTDOWN = cfg[REG_SHDN][6:0];
    assign PUMP_TEST_MODE = cfg[REG_TEST][7:5];
    assign PUMP_FAST_LOCK = cfg[REG_TEST][FAST_LOCK_BIT];
    assign LOCK_DETECT_MUX_SEL = cfg[REG_TEST][2:0];
    // Standby leaves only bus and crystal path running
    assign SIGNAL_PATH_EN = ~cfg[REG_RX][STANDBY_BIT];
    assign SYNTH_EN = ~cfg[REG_RX][STANDBY_BIT];

    // ---------------------------------------------------------
    // Checks
    // ---------------------------------------------------------
    default clocking cb @(posedge CLK_SYS);
    endclocking
    default disable iff (!RSTN);

    // Tracks whether any register was written since reset
    always_ff @(posedge CLK_SYS or negedge RSTN)
    begin
        if (!RSTN)
            any_wr <= 1'b0;
        else if (wr_seen)
            any_wr <= 1'b1;
    end

    sequence s_wr(logic [3:0] idx);
        wr_seen && wr_ptr == idx;
    endsequence

    sequence s_pulse;
        AUTOSELECT_START ##1 !AUTOSELECT_START;
    endsequence

    AST_WRITE_LANDS: assert property (
        wr_seen && wr_ptr <= CFG_LAST |=> cfg[$past(wr_ptr)] == $past(wr_byte & CFG_MASK[wr_ptr]))
        else $error("Written byte not stored");
    AST_AUTOSEL_PULSE: assert property (
        s_wr(AUTOSEL_TRIGGER_REG) |=> s_pulse)
        else $error("Autoselection start missing");
    AST_AUTOSEL_CAUSE: assert property (
        AUTOSELECT_START |-> $past(wr_seen) && $past(wr_ptr) == AUTOSEL_TRIGGER_REG)
        else $error("Autoselection start without trigger write");
    AST_INT_HIGH: assert property (
        s_wr(REG_INT_HIGH) |=> INT_DIVIDE[14:8] == $past(wr_byte[6:0]))
        else $error("Integer divider high bits wrong");
    AST_INT_LOW: assert property (
        s_wr(REG_INT_LOW) |=> INT_DIVIDE[7:0] == $past(wr_byte))
        else $error("Integer divider low bits wrong");
    AST_FRACTIONAL_MODE_BIT_TOP: assert property (
        s_wr(REG_PUMP) |=> FRACTIONAL_MODE_BIT_DIVIDE[19:16] == $past(wr_byte[3:0]))
        else $error("Fraction top bits wrong");
    AST_FRACTIONAL_MODE_BIT_MID: assert property (
        s_wr(REG_FRACTIONAL_MODE_BIT_HIGH) |=> FRACTIONAL_MODE_BIT_DIVIDE[15:8] == $past(wr_byte))
        else $error("Fraction middle bits wrong");
    AST_FRACTIONAL_MODE_BIT_LOW: assert property (
        s_wr(REG_FRACTIONAL_MODE_BIT_LOW) |=> FRACTIONAL_MODE_BIT_DIVIDE[7:0] == $past(wr_byte))
        else $error("Fraction low bits wrong");
    AST_FRACTIONAL_MODE_BIT_DEFAULT: assert property (
        !any_wr |-> FRACTIONAL_MODE_BIT_DIVIDE == FRACTIONAL_MODE_BIT_DEFAULT)
        else $error("Fraction default wrong");
    AST_DONT_CARE: assert property (
        s_wr(REG_LOOP) |=> cfg[REG_LOOP][4:0] == 5'h00 && $stable(INT_DIVIDE))
        else $error("Don't-care bits stored");
    AST_STANDBY: assert property (
        s_wr(REG_RX) ##0 wr_byte[STANDBY_BIT] |=> !SYNTH_EN && !SIGNAL_PATH_EN)
        else $error("Standby did not stop blocks");
    AST_STATUS_READ: assert property (
        ptr_seen && ptr == REG_STAT2 |=> rd_hold == $past(stat_s[7:0]))
        else $error("Status byte not refreshed");
endmodule // tcr_config_bank

// ---- verilog/tcr_pkg.sv ----
// Constants, register map and types for the tuner configuration bank
package tcr_pkg;

    // -------------------------------------------------------------
    // Register map
    // -------------------------------------------------------------
    localparam int CFG_COUNT = 12;
    localparam logic [3:0] CFG_LAST = 4'hb;
    localparam logic [3:0] REG_INT_HIGH = 4'h0;
    localparam logic [3:0] REG_INT_LOW = 4'h1;
    localparam logic [3:0] REG_PUMP = 4'h2;
    localparam logic [3:0] REG_FRACTIONAL_MODE_BIT_HIGH = 4'h3;
    localparam logic [3:0] REG_FRACTIONAL_MODE_BIT_LOW = 4'h4;
    localparam logic [3:0] REG_XTAL = 4'h5;
    localparam logic [3:0] REG_LOOP = 4'h6;
    localparam logic [3:0] REG_OSC = 4'h7;
    localparam logic [3:0] REG_LPF = 4'h8;
    localparam logic [3:0] REG_RX = 4'h9;
    localparam logic [3:0] REG_SHDN = 4'ha;
    localparam logic [3:0] REG_TEST = 4'hb;
    localparam logic [3:0] REG_STAT1 = 4'hc;
    localparam logic [3:0] REG_STAT2 = 4'hd;
    // Register number 5 of the map sits at address 0x04
    localparam logic [3:0] AUTOSEL_TRIGGER_REG = REG_FRACTIONAL_MODE_BIT_LOW;

    // -------------------------------------------------------------
    // Reset values and writable-bit masks, index = address
    // -------------------------------------------------------------
    localparam logic [7:0] CFG_RESET [CFG_COUNT] = '{
        8'h80, 8'h00, 8'h02, 8'hf6, 8'h84, 8'h01,
        8'hc0, 8'hcc, 8'h4b, 8'h00, 8'h00, 8'h08};
    localparam logic [7:0] CFG_MASK [CFG_COUNT] = '{
        8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff,
        8'he0, 8'hff, 8'hff, 8'haf, 8'h7f, 8'hef};
    localparam logic [19:0] FRACTIONAL_MODE_BIT_DEFAULT = 20'h2f684;

    // -------------------------------------------------------------
    // Field positions
    // -------------------------------------------------------------
    localparam int FRACTIONAL_MODE_BIT_MODE_BIT = 7;
    localparam int STANDBY_BIT = 7;
    localparam int FACTORY_PD_BIT = 5;
    localparam int POST_DIV_BIT = 7;
    localparam int CUR_SRC_BIT = 6;
    localparam int CUR_LVL_BIT = 5;
    localparam int AUTOSEL_BIT = 2;
    localparam int ADC_LATCH_BIT = 1;
    localparam int ADC_READ_BIT = 0;
    localparam int FAST_LOCK_BIT = 3;

    // -------------------------------------------------------------
    // Serial link
    // -------------------------------------------------------------
    localparam logic [3:0] ACK_SLOT = 4'h8;
    localparam logic [3:0] BYTE_MSB = 4'h7;
    localparam int STATUS_W = 12;

    typedef enum logic [4:0] {
        LK_ADDR = 5'h01,
        LK_PTR = 5'h02,
        LK_WDATA = 5'h04,
        LK_RDATA = 5'h08,
        LK_IGNORE = 5'h10
    } tcr_link_e;

endpackage

// ---- verilog/tcr_sync.sv ----
// Two-flop synchroniser for levels and toggles
`timescale 1ns/1ps
module tcr_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta;

    // ---------------------------------------------------------
    // Two stages, first stage read only by the second
    // ---------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meta <= '0;
            q <= '0;
        end
        else
        begin
            meta <= d;
            q <= meta;
        end
    end
endmodule // tcr_sync

// ---- verification/tcr_host_model.sv ----
// Host controller model for the two-wire configuration bus
`timescale 1ns/1ps
module tcr_host_model (
    input wire logic lclk,
    input wire logic sda,
    output logic scl,
    output logic sda_pull
);
    // ----------------------------------------------------------
    // Idle bus: clock driven high, data left to its pull-up
    // ----------------------------------------------------------
    initial
    begin
        scl = 1'b1; // Clock stands high between frames
        sda_pull = 1'b0; // Released data floats high
    end

    // ----------------------------------------------------------
    // Bit and frame timing, counted in link clock ticks
    // ----------------------------------------------------------
    task automatic ticks(input int n);
        repeat (n) @(posedge lclk);
    endtask

    // Clock pulses with data high, only seen during reset
    task automatic idle_clocks(input int n);
        repeat (n)
        begin
            scl = 1'b0;
            ticks(1);
            scl = 1'b1;
            ticks(1);
        end
    endtask

    // One bit: data moves well after the fall, sampled mid-high
    task automatic clock_bit(input logic b, output logic r);
        ticks(2);
        sda_pull = ~b;
        ticks(14);
        scl = 1'b1;
        ticks(5);
        r = sda;
        ticks(5);
        scl = 1'b0;
    endtask

    // Start, or repeated start from a low clock
    task automatic start();
        if (scl === 1'b0)
        begin
            ticks(2);
            sda_pull = 1'b0;
            ticks(14);
            scl = 1'b1;
        end
        ticks(10);
        sda_pull = 1'b1;
        ticks(10);
        scl = 1'b0;
    endtask

    // Stop: data rises while clock is high
    task automatic stop();
        ticks(2);
        sda_pull = 1'b1;
        ticks(14);
        scl = 1'b1;
        ticks(10);
        sda_pull = 1'b0;
        ticks(10);
    endtask

    // Byte out, most significant bit first, then the answer bit
    task automatic send_byte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
            clock_bit(d[i], r);
        clock_bit(1'b1, r);
        ack = ~r;
    endtask

    // Byte in; last byte is refused to end the read
    task automatic read_byte(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--)
            clock_bit(1'b1, d[i]);
        clock_bit(last, r);
    endtask
endmodule // tcr_host_model

// ---- verification/tcr_config_bank_test.sv ----
// Self-checking bench for the tuner configuration register bank
`timescale 1ns/1ps
module tcr_config_bank_test;
    import tcr_pkg::*;
    // ----------------------------------------------------------
    // Signals
    // ----------------------------------------------------------
    localparam logic [6:0] DEV_ADDR = 7'h61; // Base 60 with strap high
    localparam logic [6:0] BUS_ADDR_BASE_LOW = 7'h60; // Strap bit low
    logic clk_sys = 1'b0, lclk = 1'b0, rstn = 1'b0, addr_sel = 1'b1;
    logic scl, sda, sda_out, sda_oe_n, host_pull;
    logic por, asa, ase, lock, post_div, cur_src, cur_lvl, fractional_mode_bit_mode;
    logic [4:0] osc_num, ref_div, osc_start;
    logic [2:0] adc_val, xd, ptest, lock_detect_mux_sel;
    logic [14:0] int_div;
    logic [19:0] fractional_mode_bit_div;
    logic [1:0] pump_min, pump_lin;
    logic autosel_en, adc_latch, adc_read, fpd, fast_lock, sig_en, syn_en, autosel_start;
    logic [7:0] lpf;
    logic [3:0] baseband_gain;
    logic [6:0] shdn;
    int mismatches = 0, checks_done = 0, pulses = 0;

    always #50 clk_sys = ~clk_sys;
    always #32 lclk = ~lclk;
    assign sda = ~(host_pull | ~sda_oe_n); // Open-drain wire with pull-up
    always @(posedge clk_sys)
        if (autosel_start === 1'b1)
            pulses <= pulses + 1;

    tcr_host_model i_host (.lclk(lclk), .sda(sda), .scl(scl), .sda_pull(host_pull));

    tcr_config_bank i_dut (
        .CLK_SYS(clk_sys), .RSTN(rstn), .SCL(scl), .SDA_IN(sda), .SDA_OUT(sda_out),
        .SDA_OE_N(sda_oe_n), .ADDR_SEL(addr_sel), .POR_FLAG(por),
        .AUTOSELECT_ACTIVE_FLAG(asa), .AUTOSELECT_END_FLAG(ase), .LOCK_INDICATION(lock),
        .SELECTED_OSC_NUMBER(osc_num), .TUNE_ADC_VALUE(adc_val),
        .FRACTIONAL_MODE_BIT(fractional_mode_bit_mode), .INT_DIVIDE(int_div), .FRACTIONAL_MODE_BIT_DIVIDE(fractional_mode_bit_div),
        .PUMP_MIN_PULSE(pump_min), .PUMP_LINEARITY(pump_lin), .CRYSTAL_OUT_DIVIDER(xd),
        .REF_DIVIDER(ref_div), .OSC_POST_DIVIDER_SEL(post_div),
        .PUMP_CURRENT_SOURCE_SEL(cur_src), .PUMP_CURRENT_LEVEL(cur_lvl),
        .OSC_START_NUMBER(osc_start), .OSC_AUTOSELECT_ENABLE(autosel_en),
        .TUNE_ADC_LATCH(adc_latch), .TUNE_ADC_READ_ENABLE(adc_read), .LOWPASS_TRIM(lpf),
        .FACTORY_POWER_DOWN(fpd), .BASEBAND_GAIN(baseband_gain), .BLOCK_SHUTDOWN(shdn),
        .PUMP_TEST_MODE(ptest), .PUMP_FAST_LOCK(fast_lock), .LOCK_DETECT_MUX_SEL(lock_detect_mux_sel),
        .SIGNAL_PATH_EN(sig_en), .SYNTH_EN(syn_en), .AUTOSELECT_START(autosel_start)
    );

    // ----------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------
    task automatic check(input logic [19:0] got, input logic [19:0] exp, input string msg);
        checks_done++;
        if (got !== exp)
        begin
            mismatches++;
            $display("unexpected at %0t: %s got %h want %h", $time, msg, got, exp);
        end
    endtask

    task automatic write_regs(input logic [3:0] ptr, input logic [7:0] data [$]);
        logic ack;
        i_host.start();
        i_host.send_byte({DEV_ADDR, 1'b0}, ack);
        check(ack, 1'b1, "address ack");
        i_host.send_byte({4'h0, ptr}, ack);
        check(ack, 1'b1, "pointer ack");
        foreach (data[i])
        begin
            i_host.send_byte(data[i], ack);
            check(ack, 1'b1, "data ack");
        end
        i_host.stop();
        repeat (8) @(negedge clk_sys);
    endtask

    task automatic read_regs(input logic [3:0] ptr, input int n, output logic [7:0] q [$]);
        logic ack;
        logic [7:0] b;
        q = {};
        i_host.start();
        i_host.send_byte({DEV_ADDR, 1'b0}, ack);
        i_host.send_byte({4'h0, ptr}, ack);
        i_host.start();
        i_host.send_byte({DEV_ADDR, 1'b1}, ack);
        check(ack, 1'b1, "read address ack");
        for (int i = 0; i < n; i++)
        begin
            i_host.read_byte(i == n - 1, b);
            q.push_back(b);
        end
        i_host.stop();
    endtask

    task automatic finish_test();
        $display("mismatches %0d, checks %0d", mismatches, checks_done);
        if (mismatches == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // ----------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------
    task automatic test_reset_values();
        check(fractional_mode_bit_div, 20'd194180, "fraction default");
        check(fractional_mode_bit_div[7:0], 8'h84, "fraction low default");
        check(fractional_mode_bit_div[15:8], 8'hf6, "fraction high default");
        check({sig_en, syn_en, autosel_start}, 3'b110, "enables after reset");
        check({sda_out, sda_oe_n}, 2'b01, "data line released in reset");
    endtask

    task automatic test_config_load();
        write_regs(REG_XTAL, '{8'h01, 8'hdf, 8'hcc, 8'h97, 8'hdb, 8'h80, 8'h18});
        write_regs(REG_INT_HIGH, '{8'h80, 8'hfb, 8'h13, 8'ha5});
        check(pulses, 0, "no autoselect before trigger");
        write_regs(AUTOSEL_TRIGGER_REG, '{8'h5c});
        check(pulses, 1, "one autoselect start");
        check({fractional_mode_bit_mode, int_div}, 16'h80fb, "integer divider");
        check(fractional_mode_bit_div, 20'h3a55c, "fraction divider");
        check({pump_min, pump_lin, xd, ref_div}, 12'h101, "pump and crystal");
        check({post_div, cur_src, cur_lvl}, 3'b110, "loop bits");
        check({osc_start, autosel_en, adc_latch, adc_read}, 8'hcc, "oscillator");
        check({lpf, fpd, baseband_gain}, 13'h12eb, "filter and gain");
        check({shdn, ptest, fast_lock, lock_detect_mux_sel}, 14'h0008, "shutdown and test");
        check({sig_en, syn_en}, 2'b00, "standby disables");
    endtask

    task automatic test_standby_release();
        write_regs(REG_RX, '{8'h0b});
        check({sig_en, syn_en}, 2'b11, "standby cleared");
        check(pulses, 1, "no autoselect from other write");
    endtask

    task automatic test_status(input logic [3:0] f, input logic [4:0] osc, input logic [2:0] a);
        logic [7:0] q [$];
        @(negedge clk_sys);
        {por, asa, ase, lock} = f;
        osc_num = osc;
        adc_val = a;
        write_regs(REG_STAT1, '{8'h5a, 8'ha5});
        read_regs(REG_STAT1, 2, q);
        check(q[0], {f, 4'h0}, "status first");
        check(q[1], {osc, a}, "status second");
    endtask

    task automatic test_write_only_read();
        logic [7:0] q [$];
        read_regs(REG_INT_LOW, 1, q);
        check(q[0], 8'h00, "write-only reads zero");
    endtask

    task automatic test_wrong_address();
        logic ack;
        i_host.start();
        i_host.send_byte({BUS_ADDR_BASE_LOW, 1'b0}, ack);
        check(ack, 1'b0, "other address ignored");
        i_host.send_byte(8'h01, ack);
        i_host.send_byte(8'h33, ack);
        i_host.stop();
        repeat (8) @(negedge clk_sys);
        check(int_div, 15'h00fb, "register kept");
    endtask

    // ----------------------------------------------------------
    // Main sequence and watchdog
    // ----------------------------------------------------------
    initial
    begin
        {por, asa, ase, lock, osc_num, adc_val} = '0;
        fork
            i_host.idle_clocks(2);
        join_none
        repeat (3) @(negedge clk_sys);
        test_reset_values();
        rstn = 1'b1;
        repeat (1000) @(negedge clk_sys);
        test_config_load();
        test_standby_release();
        test_status(4'hb, 5'h13, 3'h5);
        test_status(4'h6, 5'h0a, 3'h2);
        test_write_only_read();
        test_wrong_address();
        finish_test();
    end

    initial
    begin
        repeat (100000) @(posedge clk_sys);
        mismatches++;
        $display("unexpected at %0t: run timed out", $time);
        finish_test();
    end
endmodule // tcr_config_bank_test
